// File: hw/rim_monitor.sv
// Red input qualification, monitoring gates and key supervision with Wishbone registers
`timescale 1ns/100ps
`default_nettype none
module rim_monitor #(
  parameter int KEY_SETTLE = rim_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [4:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic [31:0]                          wb_dat_o,
  output logic                                 wb_ack_o,
  output logic                                 irq_o,
  // Measured field levels, volts RMS
  input  wire logic [rim_pkg::RED_CH*8-1:0]    red_rms_i,
  input  wire logic [7:0]                      gate_rms_i,
  input  wire logic [15:0]                     pre_rms_i,
  input  wire logic                            red_input_cable_i,
  input  wire logic                            ext_reset_i,
  // Key socket
  input  wire logic                            key_power_interlock_switch_i,
  output logic                                 key_pwr_o,
  output logic                                 key_sck_o,
  output logic                                 key_cs_n_o,
  output logic                                 key_mosi_o,
  input  wire logic                            key_miso_i,
  // Classifications and monitoring enables
  output logic [rim_pkg::RED_CH-1:0]           red_active_o,
  output logic                                 gate_active_o,
  output logic [1:0]                           pre_active_o,
  output logic                                 red_fail_en_o,
  output logic                                 dual_en_o,
  output logic                                 seq_en_o,
  // Fault outputs
  output logic                                 relay_energize_o,
  output logic                                 stop_time_o,
  output logic                                 key_fault_o,
  output logic                                 diag_fault_o
);
  import rim_pkg::*;

  rim_key_if   kif ();
  rim_key_st_t key_st;           // Key supervision state
  logic        pwr;              // Socket power request
  logic        inv_pre1;         // Key option: invert preemption one
  logic        ext_d;            // Previous external reset level
  logic [IRQ_W-1:0] irq_stat;    // Sticky events
  logic [IRQ_W-1:0] irq_en;      // Event enables

  // Bus decode
  wire          wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire          wr_ok   = wb_req & wb_we_i & wb_sel_i[0];
  wire          wr_ctrl = wr_ok & (wb_adr_i == REG_CTRL);
  wire          wr_clr  = wr_ok & (wb_adr_i == REG_IRQ_CLR);
  wire          wr_en   = wr_ok & (wb_adr_i == REG_IRQ_EN);

  // One-shot reset command: held switch only counts once
  wire          rst_cmd = (ext_reset_i & ~ext_d) | (wr_ctrl & wb_dat_i[CTRL_RESET]);
  wire          seated  = key_power_interlock_switch_i;

  // Monitoring gate terms
  wire          pre_any   = |pre_active_o;
  wire          red_path  = red_input_cable_i & gate_active_o;

  // Events feeding sticky status
  wire          fail_ev   = kif.done & ~kif.ok;
  wire [IRQ_W-1:0] ev;
  assign ev[EV_KEY_OK]    = kif.done & kif.ok;
  assign ev[EV_KEY_FAULT] = (key_st == RIM_KEY_OK) & ~seated | fail_ev;
  assign ev[EV_DIAG]      = fail_ev & ~diag_fault_o;
  assign ev[EV_GATE]      = gate_active_o != rim_classify(gate_active_o, gate_rms_i, 1'b0);

  // Status word
  wire [31:0] status_w = {24'h000000, inv_pre1, red_input_cable_i, pre_active_o,
                          gate_active_o, diag_fault_o, key_fault_o, key_st == RIM_KEY_OK};

  // Read data select; unmapped offsets read zero
  wire [31:0] rd_mux =
      (wb_adr_i == REG_STATUS)   ? status_w :
      (wb_adr_i == REG_RED)      ? {16'h0000, red_active_o} :
      (wb_adr_i == REG_IRQ_STAT) ? {28'h0000000, irq_stat} :
      (wb_adr_i == REG_IRQ_EN)   ? {28'h0000000, irq_en} :
      (wb_adr_i == REG_KEY_FCS)  ? {16'h0000, kif.fcs} : 32'h00000000;

  assign key_pwr_o   = pwr & seated;
  assign kif.powered = key_pwr_o;
  assign irq_o       = |(irq_stat & irq_en);

  // Bus answer: ack one cycle after request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
    end
  end

  // Interrupt status and enable; a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_en   <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_clr ? wb_dat_i[IRQ_W-1:0] : '0)) | ev;
      if (wr_en) begin
        irq_en <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // Input classification, updated every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      red_active_o  <= '0;
      gate_active_o <= 1'b0;
      pre_active_o  <= 2'b00;
    end else begin
      for (int i = 0; i < RED_CH; i++) begin
        red_active_o[i] <= rim_classify(red_active_o[i], red_rms_i[i*8 +: 8], 1'b0);
      end
      gate_active_o   <= rim_classify(gate_active_o, gate_rms_i, 1'b0);
      pre_active_o[0] <= rim_classify(pre_active_o[0], pre_rms_i[7:0], inv_pre1);
      pre_active_o[1] <= rim_classify(pre_active_o[1], pre_rms_i[15:8], 1'b0);
    end
  end

  // Monitoring enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      red_fail_en_o <= 1'b0;
      dual_en_o     <= 1'b0;
      seq_en_o      <= 1'b0;
    end else begin
      red_fail_en_o <= red_path & ~pre_any;
      dual_en_o     <= red_path;
      seq_en_o      <= red_path;
    end
  end

  // Key supervision: power, read, fault latch and reset exit
  always_ff @(posedge clk_i) begin
    kif.start <= 1'b0;
    if (rst_i) begin
      key_st       <= RIM_KEY_OFF;
      pwr          <= 1'b0;
      inv_pre1     <= 1'b0;
      ext_d        <= 1'b0;
      key_fault_o  <= 1'b1;
      diag_fault_o <= 1'b0;
    end else begin
      ext_d <= ext_reset_i;
      if (fail_ev) begin
        diag_fault_o <= 1'b1;
      end
      unique case (key_st)
        RIM_KEY_OFF: begin
          pwr <= 1'b0;
          if (seated) begin
            pwr       <= 1'b1;
            kif.start <= 1'b1;
            key_st    <= RIM_KEY_READ;
          end
        end
        RIM_KEY_READ: begin
          if (kif.done) begin
            key_st   <= kif.ok ? RIM_KEY_OK : RIM_KEY_BAD;
            inv_pre1 <= kif.ok & kif.opt[OPT_INV_PRE1];
          end else if (!seated) begin
            key_st <= RIM_KEY_OFF;
          end
        end
        RIM_KEY_OK: begin
          if (!seated) begin
            key_fault_o <= 1'b1;
            key_st      <= RIM_KEY_OFF;
          end else if (rst_cmd) begin
            key_fault_o <= 1'b0;
          end
        end
        RIM_KEY_BAD: begin
          key_fault_o <= 1'b1;
          if (!seated) begin
            key_st <= RIM_KEY_OFF;
          end
        end
      endcase
      if (!seated) begin
        pwr <= 1'b0;
      end
    end
  end

  // fault drops relay and asserts stop time
  assign relay_energize_o = ~key_fault_o & ~diag_fault_o;
  assign stop_time_o      = ~relay_energize_o;

  // Key reader
  rim_key_reader #(
    .SETTLE (KEY_SETTLE)
  ) u_reader (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .kif        (kif.rdr),
    .key_sck_o  (key_sck_o),
    .key_cs_n_o (key_cs_n_o),
    .key_mosi_o (key_mosi_o),
    .key_miso_i (key_miso_i)
  );
endmodule
`default_nettype wire

// File: hw/rim_pkg.sv
// Constants, register map and helper functions for the red input monitor and key check
// Operation
// - Key is read only, never written
// - Key data checked with 16-bit HDLC FCS
// - Failed key read latches a diagnostic fault
// - Key pins unpowered unless interlock switch closed
// - Sixteen independent red channel inputs classified
// - Red active above 70, inactive below 50
// - Gate input uses same 70/50 thresholds
// - Red, dual, sequence monitoring need active gate
// - Either preemption input suppresses red fail only
// - Preemption inputs use same 70/50 thresholds
// - Key option inverts preemption input one
// - Without red cable, run as basic monitor
// - Key fault drops relay, needs reset to exit
package rim_pkg;

  // Input levels and thresholds, in whole volts RMS
  localparam int          RMS_W       = 8;
  localparam logic [7:0]  RMS_ON_V    = 8'h46;  // 70 Vrms
  localparam logic [7:0]  RMS_OFF_V   = 8'h32;  // 50 Vrms
  localparam int          RED_CH      = 16;

  // Clock and key timing
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          SETTLE_US    = 1000;                     // Power settle after seating
  localparam int          SETTLE_CYC   = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int          SCK_HALF_NS  = 500;                      // Key clock half period
  localparam int          SCK_HALF_CYC = (SCK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;

  // Key transaction layout
  localparam logic [7:0]  KEY_OP_READ  = 8'h03;   // The only opcode ever sent
  localparam int          KEY_BYTES    = 512;
  localparam int          CMD_BITS     = 24;
  localparam int          TOTAL_BITS   = CMD_BITS + KEY_BYTES * 8;
  localparam int          BITCNT_W     = 13;
  localparam logic [12:0] CMD_BITS_C   = 13'h0018;
  localparam logic [12:0] LAST_BIT_C   = 13'h1017;  // TOTAL_BITS - 1
  localparam logic [8:0]  OPT_BYTE_IDX = 9'h000;    // Option byte position in key
  localparam int          OPT_INV_PRE1 = 0;         // Invert preemption one

  // Frame check sequence
  localparam logic [15:0] FCS_INIT    = 16'hffff;
  localparam logic [15:0] FCS_POLY    = 16'h8408;
  localparam logic [15:0] FCS_GOOD    = 16'hf0b8;

  // Register byte offsets
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h04;
  localparam logic [4:0]  REG_RED      = 5'h08;
  localparam logic [4:0]  REG_IRQ_STAT = 5'h0c;
  localparam logic [4:0]  REG_IRQ_CLR  = 5'h10;
  localparam logic [4:0]  REG_IRQ_EN   = 5'h14;
  localparam logic [4:0]  REG_KEY_FCS  = 5'h18;

  // Control bits
  localparam int          CTRL_RESET   = 0;   // Write 1: monitor reset command
  // Interrupt event bits
  localparam int          IRQ_W        = 4;
  localparam int          EV_KEY_OK    = 0;
  localparam int          EV_KEY_FAULT = 1;
  localparam int          EV_DIAG      = 2;
  localparam int          EV_GATE      = 3;

  // Key supervision states
  typedef enum logic [1:0] {
    RIM_KEY_OFF  = 2'b00,
    RIM_KEY_READ = 2'b01,
    RIM_KEY_OK   = 2'b10,
    RIM_KEY_BAD  = 2'b11
  } rim_key_st_t;

  // Threshold classifier with hysteresis; inv swaps the active sense
  function automatic logic rim_classify(input logic prev, input logic [7:0] rms,
                                        input logic inv);
    if (rms > RMS_ON_V) begin
      return ~inv;
    end else if (rms < RMS_OFF_V) begin
      return inv;
    end
    return prev;
  endfunction

  // One byte into the HDLC FCS, least significant bit first
  function automatic logic [15:0] rim_fcs_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ b[i]) begin
        c = (c >> 1) ^ FCS_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

// File: hw/rim_key_if.sv
// Carrier between key supervisor and key reader
`timescale 1ns/100ps
`default_nettype none
interface rim_key_if;
  logic        start;    // Pulse: begin one full key read
  logic        powered;  // Key socket powered
  logic        busy;     // Read in progress
  logic        done;     // Pulse: read finished
  logic        ok;       // With done: FCS matched
  logic [7:0]  opt;      // Captured option byte
  logic [15:0] fcs;      // Final FCS register value

  modport ctl (output start, output powered, input busy, input done, input ok,
               input opt, input fcs);
  modport rdr (input start, input powered, output busy, output done, output ok,
               output opt, output fcs);
endinterface
`default_nettype wire

// File: hw/rim_key_reader.sv
// Serial key reader: read-only command, bit shifting and FCS check
`timescale 1ns/100ps
`default_nettype none
module rim_key_reader #(
  parameter int SETTLE = rim_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Supervisor side
  rim_key_if.rdr    kif,
  // Key pins
  output logic      key_sck_o,
  output logic      key_cs_n_o,
  output logic      key_mosi_o,
  input  wire logic key_miso_i
);
  import rim_pkg::*;

  logic [15:0]         settle;     // Power settle counter
  logic                running;    // Shifting in progress
  logic [7:0]          half;       // Key clock phase counter
  logic [BITCNT_W-1:0] bitcnt;     // Bits done in frame
  logic [23:0]         cmd_sh;     // Outgoing command
  logic [7:0]          rx;         // Incoming byte
  logic [15:0]         crc;        // Running FCS

  // Decodes for clock edges and byte completion
  wire        half_end  = (half == 8'(SCK_HALF_CYC - 1));
  wire        rise      = running & half_end & ~key_sck_o;
  wire        fall      = running & half_end & key_sck_o;
  wire        data_bit  = (bitcnt >= CMD_BITS_C);
  wire [12:0] data_idx  = bitcnt - CMD_BITS_C;
  wire [7:0]  rx_next   = {rx[6:0], key_miso_i};
  wire        byte_end  = rise & data_bit & (data_idx[2:0] == 3'h7);
  wire        last_fall = fall & (bitcnt == LAST_BIT_C);

  assign kif.busy = running | (settle != 16'h0000);

  // Settle wait after a start request
  always_ff @(posedge clk_i) begin
    if (rst_i || !kif.powered) begin
      settle <= 16'h0000;
    end else if (kif.start) begin
      settle <= 16'(SETTLE);
    end else if (settle != 16'h0000) begin
      settle <= settle - 16'h0001;
    end
  end

  // Frame engine; a power loss aborts the frame and reports failure
  always_ff @(posedge clk_i) begin
    kif.done <= 1'b0;
    if (rst_i) begin
      running    <= 1'b0;
      half       <= 8'h00;
      bitcnt     <= '0;
      key_sck_o  <= 1'b0;
      key_cs_n_o <= 1'b0;
      key_mosi_o <= 1'b0;
      cmd_sh     <= 24'h000000;
      rx         <= 8'h00;
      crc        <= FCS_INIT;
      kif.ok     <= 1'b0;
      kif.opt    <= 8'h00;
      kif.fcs    <= 16'h0000;
    end else if (!kif.powered) begin
      if (running) begin
        kif.done <= 1'b1;
        kif.ok   <= 1'b0;
      end
      running    <= 1'b0;
      key_sck_o  <= 1'b0;
      key_cs_n_o <= 1'b0;
      key_mosi_o <= 1'b0;
    end else if (settle == 16'h0001) begin
      running    <= 1'b1;
      half       <= 8'h00;
      bitcnt     <= '0;
      key_cs_n_o <= 1'b0;
      key_sck_o  <= 1'b0;
      cmd_sh     <= {KEY_OP_READ, 16'h0000};
      key_mosi_o <= KEY_OP_READ[7];
      crc        <= FCS_INIT;
    end else if (running) begin
      half <= half_end ? 8'h00 : half + 8'h01;
      if (half_end) begin
        key_sck_o <= ~key_sck_o;
      end
      if (byte_end) begin
        crc <= rim_fcs_byte(crc, rx_next);
        if (data_idx[11:3] == OPT_BYTE_IDX) begin
          kif.opt <= rx_next;
        end
      end
      if (rise && data_bit) begin
        rx <= rx_next;
      end
      if (last_fall) begin
        running    <= 1'b0;
        key_cs_n_o <= 1'b1;
        kif.done   <= 1'b1;
        kif.ok     <= (crc == FCS_GOOD);
        kif.fcs    <= crc;
      end else if (fall) begin
        bitcnt     <= bitcnt + 13'h0001;
        cmd_sh     <= {cmd_sh[22:0], 1'b0};
        key_mosi_o <= cmd_sh[22];
      end
    end else begin
      key_cs_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/rim_monitor_asserts.sv
// Port assertions for the red input monitor
`timescale 1ns/100ps
`default_nettype none
module rim_monitor_asserts import rim_pkg::*; (
  // Clock, reset, bus
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  // Levels, classes, enables
  input wire logic [RED_CH*8-1:0]   red_rms_i,
  input wire logic [7:0]            gate_rms_i,
  input wire logic                  red_input_cable_i,
  input wire logic [RED_CH-1:0]     red_active_o,
  input wire logic                  gate_active_o,
  input wire logic [1:0]            pre_active_o,
  input wire logic                  red_fail_en_o,
  input wire logic                  dual_en_o,
  input wire logic                  seq_en_o,
  // Key socket and faults
  input wire logic                  key_power_interlock_switch_i,
  input wire logic                  key_pwr_o,
  input wire logic                  key_sck_o,
  input wire logic                  key_cs_n_o,
  input wire logic                  key_mosi_o,
  input wire logic                  relay_energize_o,
  input wire logic                  stop_time_o,
  input wire logic                  key_fault_o,
  input wire logic                  diag_fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [7:0] ch0 = red_rms_i[7:0];  // Channel zero level stands for all
  wire logic       req = wb_cyc_i && wb_stb_i && !wb_ack_o;  // New bus request
  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_red_on_level: assert property (ch0 > RMS_ON_V |=> red_active_o[0])
    else $error("red channel not active above on level");
  a_red_off_level: assert property (ch0 < RMS_OFF_V |=> !red_active_o[0])
    else $error("red channel active below off level");
  a_red_hold_band: assert property ((ch0 >= RMS_OFF_V && ch0 <= RMS_ON_V)
    |=> red_active_o[0] == $past(red_active_o[0])) else $error("red class moved in band");
  a_gate_on_off: assert property ((gate_rms_i > RMS_ON_V |=> gate_active_o) and
    (gate_rms_i < RMS_OFF_V |=> !gate_active_o)) else $error("gate class wrong");
  a_gate_blocks_all: assert property (!gate_active_o
    |=> !(dual_en_o || seq_en_o || red_fail_en_o)) else $error("monitoring enabled without gate");
  a_pre_blocks_fail: assert property (|pre_active_o |=> !red_fail_en_o)
    else $error("red fail enabled during preemption");
  a_no_cable_basic: assert property (!red_input_cable_i && !$past(red_input_cable_i)
    |=> !(dual_en_o || seq_en_o || red_fail_en_o)) else $error("red functions without cable");
  a_pwr_needs_seat: assert property (key_pwr_o |-> key_power_interlock_switch_i)
    else $error("key powered while unseated");
  a_dead_socket: assert property (!key_pwr_o && !$past(key_pwr_o)
    |-> !(key_sck_o || key_cs_n_o || key_mosi_o)) else $error("key pins live unpowered");
  a_fault_drops_relay: assert property ((key_fault_o || diag_fault_o)
    |-> !relay_energize_o && stop_time_o) else $error("relay up during fault");
  a_diag_latched: assert property (diag_fault_o |=> diag_fault_o)
    else $error("diagnostic fault released");
  c_fail_en: cover property (red_fail_en_o ##1 !red_fail_en_o);
  c_key_cycle: cover property (key_pwr_o ##1 !key_pwr_o);
  c_diag: cover property ($rose(diag_fault_o));
endmodule
bind rim_monitor rim_monitor_asserts u_rim_monitor_asserts (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .red_rms_i, .gate_rms_i, .red_input_cable_i, .red_active_o,
  .gate_active_o, .pre_active_o, .red_fail_en_o, .dual_en_o, .seq_en_o,
  .key_power_interlock_switch_i, .key_pwr_o, .key_sck_o, .key_cs_n_o, .key_mosi_o,
  .relay_energize_o, .stop_time_o, .key_fault_o, .diag_fault_o);
`default_nettype wire

// File: testbench/rim_key_model.sv
// Behavioural serial configuration key behind its socket
`timescale 1ns/100ps
`default_nettype none
module rim_key_model (
  // Socket pins
  input  wire logic   pwr_i,
  input  wire logic   sck_i,
  input  wire logic   cs_n_i,
  input  wire logic   mosi_i,
  output logic        miso_o,
  // What the reader sent
  output logic [12:0] bits_o,
  output logic [23:0] cmd_o
);
  logic [7:0]  mem [512];  // Key storage
  logic        dbit;       // Last bit put out
  logic [12:0] d;          // Data bit index
  wire logic   sel = pwr_i && !cs_n_i;  // Powered and selected
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i * 37);
    end
    bits_o = '0;
    cmd_o = '0;
    dbit = 1'b0;
  end
  assign d = bits_o - 13'd24;
  // Count bits and keep the command; deselect or power loss restarts
  always @(posedge sck_i or posedge cs_n_i or negedge pwr_i) begin
    if (!sel) begin
      bits_o <= '0;
    end else begin
      bits_o <= bits_o + 13'd1;
      if (bits_o < 13'd24) begin
        cmd_o <= {cmd_o[22:0], mosi_i};
      end
    end
  end
  // Data moves on the falling edge, MSB first
  always @(negedge sck_i) begin
    if (sel && bits_o >= 13'd24) begin
      dbit <= mem[d[11:3]][3'd7 - d[2:0]];
    end
  end
  // A released line shows the opposite of its last bit, never a held value
  assign miso_o = sel ? dbit : ~dbit;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the red input monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, ac); end end
module tb_top import rim_pkg::*; ;
  // Clock, reset and bus
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [4:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o;
  // Field levels, classes, enables
  logic [127:0] red_rms_i;
  logic [7:0]   gate_rms_i;
  logic [15:0]  pre_rms_i, red_active_o;
  logic [1:0]   pre_active_o;
  logic         red_input_cable_i, ext_reset_i, gate_active_o;
  logic         red_fail_en_o, dual_en_o, seq_en_o;
  // Key socket and faults
  logic         key_power_interlock_switch_i, key_pwr_o, key_sck_o, key_cs_n_o;
  logic         key_mosi_o, key_miso_i, relay_energize_o, stop_time_o;
  logic         key_fault_o, diag_fault_o;
  logic [12:0]  key_bits;  // Bits the key has seen
  logic [23:0]  key_cmd;   // Command the key has seen
  // Fault outputs gathered: key fault, diag fault, relay, stop time
  wire logic [3:0] faults = {key_fault_o, diag_fault_o, relay_energize_o, stop_time_o};
  int           err_count = 0;
  int           compares = 0;
  int           cyc_n = 0;
  // Levels around both thresholds and the class each must give
  logic [7:0]   lv [7] = '{8'h47, 8'h46, 8'h32, 8'h31, 8'h32, 8'h46, 8'h47};
  logic [6:0]   lex = 7'b1000111;
  // Enable cases: cable, gate, pre one, pre two; expected fail, dual, seq
  logic [3:0]   en_in [5] = '{4'b1100, 4'b1110, 4'b1101, 4'b1000, 4'b0100};
  logic [2:0]   en_ex [5] = '{3'b111, 3'b011, 3'b011, 3'b000, 3'b000};
  // Design, short settle time keeps the key test brief
  rim_monitor #(.KEY_SETTLE(4)) u_rim_monitor (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .red_rms_i, .gate_rms_i, .pre_rms_i, .red_input_cable_i,
    .ext_reset_i, .key_power_interlock_switch_i, .key_pwr_o, .key_sck_o, .key_cs_n_o,
    .key_mosi_o, .key_miso_i, .red_active_o, .gate_active_o, .pre_active_o, .red_fail_en_o,
    .dual_en_o, .seq_en_o, .relay_energize_o, .stop_time_o, .key_fault_o, .diag_fault_o);
  // Key on the far side of the socket
  rim_key_model u_rim_key_model (.pwr_i(key_pwr_o), .sck_i(key_sck_o), .cs_n_i(key_cs_n_o),
    .mosi_i(key_mosi_o), .miso_o(key_miso_i), .bits_o(key_bits), .cmd_o(key_cmd));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Hang guard, far above the roughly 1400 cycles needed
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; the idle cycle after keeps requests apart
  // Waits for ack however long it takes; only the hang guard ends a stuck wait
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {red_rms_i, gate_rms_i, pre_rms_i} = '0;
    {red_input_cable_i, ext_reset_i, key_power_interlock_switch_i} = '0;
    tk(3);
    rst_i <= 1'b0;
    tk(1);
    // Reset state and registers
    `CHK("fault outputs", 4'b1001, faults)
    `CHK("key power", 1'b0, key_pwr_o)
    rd(REG_STATUS, 32'h2, "status");
    rd(5'h1c, 32'h0, "unmapped");
    wr(REG_IRQ_EN, 32'h8);
    rd(REG_IRQ_EN, 32'h8, "irq enable");
    $display("test registers done");
    // Odd channels held high, even ones walked across both thresholds
    for (int k = 0; k < 7; k++) begin
      for (int c = 0; c < 16; c++) begin
        red_rms_i[8*c +: 8] <= c[0] ? 8'h64 : lv[k];
      end
      gate_rms_i <= lv[k];
      pre_rms_i <= {lv[k], lv[k]};
      tk(3);
      `CHK("red classes", lex[k] ? 16'hffff : 16'haaaa, red_active_o)
      `CHK("gate class", lex[k], gate_active_o)
      `CHK("pre classes", {lex[k], lex[k]}, pre_active_o)
    end
    $display("test classification done");
    for (int k = 0; k < 5; k++) begin
      red_input_cable_i <= en_in[k][3];
      gate_rms_i <= en_in[k][2] ? 8'h64 : 8'h00;
      pre_rms_i <= {en_in[k][0] ? 8'h64 : 8'h00, en_in[k][1] ? 8'h64 : 8'h00};
      tk(4);
      `CHK("enables", en_ex[k], {red_fail_en_o, dual_en_o, seq_en_o})
    end
    $display("test enables done");
    // Gate changes raised events; clear, mask, unmask
    `CHK("irq raised", 1'b1, irq_o)
    rd(REG_IRQ_STAT, 32'h8, "irq status");
    wr(REG_IRQ_CLR, 32'h8);
    `CHK("irq cleared", 1'b0, irq_o)
    wr(REG_IRQ_EN, 32'h0);
    gate_rms_i <= 8'h00;
    tk(3);
    `CHK("irq masked", 1'b0, irq_o)
    rd(REG_IRQ_STAT, 32'h8, "masked status");
    wr(REG_IRQ_EN, 32'h6);
    wr(REG_IRQ_CLR, 32'h8);
    $display("test interrupts done");
    // Seat the key, let the command pass, pull it mid-read
    key_power_interlock_switch_i <= 1'b1;
    tk(2);
    `CHK("key powered", 1'b1, key_pwr_o)
    for (int n = 0; n < 5000 && key_bits < 13'd32; n++) begin
      tk(1);
    end
    `CHK("key command", {KEY_OP_READ, 16'h0000}, key_cmd)
    key_power_interlock_switch_i <= 1'b0;
    tk(1);
    `CHK("key unpowered", 1'b0, key_pwr_o)
    tk(3);
    `CHK("abort faults", 4'b1101, faults)
    `CHK("irq key", 1'b1, irq_o)
    rd(REG_IRQ_STAT, 32'h6, "key events");
    rd(REG_STATUS, 32'h6, "fault status");
    // A reset command while no valid key is seated must not lift either fault
    wr(REG_CTRL, 32'h1);
    ext_reset_i <= 1'b1;
    tk(2);
    ext_reset_i <= 1'b0;
    tk(3);
    `CHK("faults held", 2'b11, {key_fault_o, diag_fault_o})
    $display("test key abort done");
    complete_run();
  end
endmodule
`default_nettype wire
